// ==== hdl/seq_pkg.sv ====
/*
 * Shared constants and types for the reset and sleep sequencing link
 * between the processor-side control end and the system sequencer end.
 * Assumes one 20 MHz clock shared by both ends.
 */
package seq_pkg;
    localparam int CLK_MHZ = 20;
    // Times in their own units, cycle counts derived from the clock rate
    localparam int ASYNC_MIN_CYC = 2;
    localparam int PG_TO_RST_MIN_MS = 1;
    localparam int PG_TO_RST_MAX_MS = 10;
    localparam int PG_TO_RST_MIN_CYC = PG_TO_RST_MIN_MS * 1000 * CLK_MHZ;
    localparam int PG_LOW_MIN_CYC = 10;
    localparam int HOT_MIN_US = 500;
    localparam int HOT_MIN_CYC = HOT_MIN_US * CLK_MHZ;
    localparam int FLOAT_ERROR_N_MAX_CYC = 5;
    localparam int STRAP_SETUP_CYC = 4;
    localparam int STRAP_HOLD_MIN_CYC = 2;
    localparam int STRAP_HOLD_MAX_CYC = 20;
    localparam int TRST_MIN_TCK = 2;
    localparam int SLP_AFTER_GRANT_CYC = 100;
    localparam int STABLE_BEFORE_SLP_CYC = 10;
    localparam int SLP_TO_DEEP_SLEEP_REQ_N_CYC = 10;
    localparam int LOCK_MAX_US = 30;
    localparam int LOCK_CYC = LOCK_MAX_US * CLK_MHZ;
    localparam int HALT_HOLD_CYC = 10;
    localparam int INPUT_HOLD_CYC = 10;
    localparam int VID_MAX_US = 10;
    localparam int VID_MAX_CYC = VID_MAX_US * CLK_MHZ;
    localparam int VID_W = 5;
    localparam int CNT_W = 32;
    // Latency of the two-flop synchronisers on link inputs
    localparam int SYNC_CYC = 2;
    localparam logic [VID_W-1:0] VID_RESET = 5'h00;

    // System sequencer states (one-hot)
    typedef enum logic [9:0] {
        S_OFF      = 10'h001,
        S_PG_LOW   = 10'h002,
        S_RESET    = 10'h004,
        S_HOLD     = 10'h008,
        S_RUN      = 10'h010,
        S_GRANTED  = 10'h020,
        S_SLEEP    = 10'h040,
        S_DEEP     = 10'h080,
        S_LOCK     = 10'h100,
        S_WAKE     = 10'h200
    } sys_state_t;
endpackage : seq_pkg

// ==== hdl/seq_if.sv ====
/*
 * Interface joining the processor end and the system end.
 * Assumes both ends share clk; active-low pins keep the _n suffix.
 */
`timescale 1ns/10ps
interface seq_if;
    import seq_pkg::*;
    logic power_good_in;
    logic bus_reset_n;
    logic clock_halt_req_n;
    logic sleep_req_n;
    logic deep_sleep_req_n;
    logic [31:3] addr_strap;
    logic bus_request0_strap_n;
    logic warm_restart_n;
    logic mgmt_interrupt_n;
    logic stop_grant;
    logic thermal_alert_n;
    logic overheat_trip_n;
    logic float_error_n;
    logic [VID_W-1:0] voltage_code_out;
    logic tck;
    logic trst_n;
    logic tms;
    logic tdi;
    logic tdo;

    modport cpu (
        input power_good_in, bus_reset_n, clock_halt_req_n, sleep_req_n,
        input deep_sleep_req_n, addr_strap, bus_request0_strap_n,
        input warm_restart_n, mgmt_interrupt_n, tck, trst_n, tms, tdi,
        output stop_grant, thermal_alert_n, overheat_trip_n,
        output float_error_n, voltage_code_out, tdo
    );
    modport sys (
        output power_good_in, bus_reset_n, clock_halt_req_n, sleep_req_n,
        output deep_sleep_req_n, addr_strap, bus_request0_strap_n,
        output warm_restart_n, mgmt_interrupt_n, tck, trst_n, tms, tdi,
        input stop_grant, thermal_alert_n, overheat_trip_n,
        input float_error_n, voltage_code_out, tdo
    );
endinterface : seq_if

// ==== hdl/sys_sequencer.sv ====
/*
 * System end: drives power-good, bus reset, straps, halt, sleep and
 * deep-sleep in the documented order, plus a test-port reset pulse.
 * Assumes the processor end on the same clk; user controls are
 * synchronous pulses/levels from logic on clk.
 */
`timescale 1ns/10ps
module sys_sequencer
    import seq_pkg::*;
#(
    parameter int RESET_HOLD_CYC = PG_TO_RST_MIN_CYC,
    parameter int TRIP_OFF_CYC = 10_000_000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // User side
    input wire logic power_on,
    input wire logic sleep_cmd,
    input wire logic deep_cmd,
    input wire logic wake_cmd,
    input wire logic test_reset_cmd,
    input wire logic [31:3] strap_addr_cfg,
    input wire logic strap_br0_cfg,
    output logic running,
    output logic in_deep_sleep,
    output logic vcore_enable,
    output logic [VID_W-1:0] voltage_code_seen,
    // Processor link
    seq_if.sys link
);
    sys_state_t state, next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] trip_cnt;
    logic [2:0] trst_cnt;
    logic tck_div;
    logic halt_n, slp_n, deep_sleep_req_n_n, rst_n_q, pg_q;
    logic [31:3] strap_q;
    logic br0_n_q, trst_q, tdi_q;

    // Two-stage synchronisers for the processor's grant, trip and voltage code outputs
    logic grant_s1, grant_s2, trip_s1, trip_s2;
    logic [VID_W-1:0] vid_s1, vid_s2;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            grant_s1 <= 1'b0;
            grant_s2 <= 1'b0;
            trip_s1 <= 1'b1;
            trip_s2 <= 1'b1;
            vid_s1 <= VID_RESET;
            vid_s2 <= VID_RESET;
        end else begin
            grant_s1 <= link.stop_grant;
            grant_s2 <= grant_s1;
            trip_s1 <= link.overheat_trip_n;
            trip_s2 <= trip_s1;
            vid_s1 <= link.voltage_code_out;
            vid_s2 <= vid_s1;
        end
    end

    function automatic logic reached(input logic [CNT_W-1:0] c,
                                     input int n);
        reached = (c >= CNT_W'(n - 1));
    endfunction : reached

    wire tripped = !trip_s2;
    wire pg_low_done = reached(cnt, PG_LOW_MIN_CYC);
    wire rst_done = reached(cnt, RESET_HOLD_CYC);
    wire strap_done = reached(cnt, STRAP_HOLD_MIN_CYC + 1);
    wire grant_done = reached(cnt, SLP_AFTER_GRANT_CYC);
    wire deep_ok = reached(cnt, SLP_TO_DEEP_SLEEP_REQ_N_CYC);
    wire lock_done = reached(cnt, LOCK_CYC);
    wire wake_done = reached(cnt, HALT_HOLD_CYC);

    always_comb begin
        next_state = state;
        case (state)
            S_OFF: if (power_on) next_state = S_PG_LOW;
            S_PG_LOW: if (pg_low_done) next_state = S_RESET;
            S_RESET: if (rst_done) next_state = S_HOLD;
            S_HOLD: if (strap_done) next_state = S_RUN;
            S_RUN: if (sleep_cmd) next_state = S_GRANTED;
            S_GRANTED: if (grant_s2 && grant_done) next_state = S_SLEEP;
            S_SLEEP: begin
                if (deep_cmd && deep_ok) next_state = S_DEEP;
                else if (wake_cmd) next_state = S_WAKE;
            end
            S_DEEP: if (wake_cmd) next_state = S_LOCK;
            S_LOCK: if (lock_done) next_state = S_WAKE;
            S_WAKE: if (wake_done) next_state = S_RUN;
            default: next_state = S_OFF;
        endcase
        if (!power_on || tripped) next_state = S_OFF;
    end

    wire count_reset = (next_state != state) ||
                       (state == S_GRANTED && !grant_s2);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= S_OFF;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= count_reset ? '0 : cnt + CNT_W'(1);
        end
    end

    // Levels registered so every link pin changes on a clk edge and holds
    // for whole states; the timed ones last over two cycles, but S_RUN, S_SLEEP and S_DEEP can end after one.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pg_q <= 1'b0;
            rst_n_q <= 1'b0;
            halt_n <= 1'b1;
            slp_n <= 1'b1;
            deep_sleep_req_n_n <= 1'b1;
        end else begin
            pg_q <= !(next_state inside {S_OFF, S_PG_LOW});
            // Assert may come at once; release only on a clk edge
            rst_n_q <= !(next_state inside {S_OFF, S_PG_LOW, S_RESET});
            halt_n <= !(next_state inside
                {S_GRANTED, S_SLEEP, S_DEEP, S_LOCK, S_WAKE});
            slp_n <= !(next_state inside {S_SLEEP, S_DEEP, S_LOCK});
            deep_sleep_req_n_n <= !(next_state == S_DEEP);
        end
    end

    // The trip arrives late by the synchroniser; the timer runs that short
    wire trip_off = reached(trip_cnt, TRIP_OFF_CYC - SYNC_CYC);

    // Power-off timer after an overheat trip
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trip_cnt <= '0;
            vcore_enable <= 1'b0;
        end else begin
            if (!tripped) trip_cnt <= '0;
            else if (!trip_off) trip_cnt <= trip_cnt + CNT_W'(1);
            vcore_enable <= power_on && !(tripped && trip_off);
        end
    end

    // Test clock divided by two; test reset held for TRST_MIN_TCK+1 periods
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tck_div <= 1'b0;
            trst_cnt <= 3'h0;
        end else begin
            tck_div <= !tck_div;
            if (test_reset_cmd) trst_cnt <= 3'(2 * TRST_MIN_TCK + 2);
            else if (trst_cnt != 3'h0) trst_cnt <= trst_cnt - 3'h1;
        end
    end

    // Straps, test reset and test data leave from flip-flops; test data changes as the
    // test clock falls so it is steady at the rising edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_q <= '0;
            br0_n_q <= 1'b1;
            trst_q <= 1'b1;
            tdi_q <= 1'b0;
        end else begin
            strap_q <= strap_addr_cfg;
            br0_n_q <= !strap_br0_cfg;
            trst_q <= (trst_cnt == 3'h0);
            tdi_q <= tdi_q ^ tck_div;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            running <= 1'b0;
            in_deep_sleep <= 1'b0;
            voltage_code_seen <= VID_RESET;
        end else begin
            running <= (state == S_RUN);
            in_deep_sleep <= (state == S_DEEP);
            voltage_code_seen <= vid_s2;
        end
    end

    assign link.power_good_in = pg_q;
    assign link.bus_reset_n = rst_n_q;
    assign link.clock_halt_req_n = halt_n;
    assign link.sleep_req_n = slp_n;
    assign link.deep_sleep_req_n = deep_sleep_req_n_n;
    // Straps follow the configuration from reset onward, well before release
    assign link.addr_strap = strap_q;
    assign link.bus_request0_strap_n = br0_n_q;
    assign link.warm_restart_n = 1'b1;
    assign link.mgmt_interrupt_n = 1'b1;
    assign link.tck = tck_div;
    assign link.trst_n = trst_q;
    assign link.tms = 1'b1;
    assign link.tdi = tdi_q;
endmodule : sys_sequencer

// ==== hdl/cpu_power_ctrl.sv ====
/*
 * Processor end: catches reset straps, answers halt with a stop grant,
 * drives float error, thermal alert, trip, voltage code and a one-bit
 * test data path. Assumes the system end obeys the ordering it owns.
 */
`timescale 1ns/10ps
module cpu_power_ctrl
    import seq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // User side
    input wire logic hot_event,
    input wire logic trip_event,
    input wire logic fp_error,
    input wire logic [VID_W-1:0] deep_voltage_code,
    input wire logic [VID_W-1:0] run_voltage_code,
    output logic [31:3] strap_addr,
    output logic strap_br0,
    output logic in_reset,
    output logic sleeping,
    // System link
    seq_if.cpu link
);
    logic [CNT_W-1:0] hot_cnt;
    logic rst_s1, rst_s2, rst_d, halt_s1, halt_s2, halt_d;
    logic slp_s1, slp_s2, dp_s1, dp_s2;
    logic hot_n, trip_n, float_error_n_n, grant, tdi_q, tdo_q, float_error_n_lat;
    logic [VID_W-1:0] vid;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
            halt_s1 <= 1'b1;
            halt_s2 <= 1'b1;
            slp_s1 <= 1'b1;
            slp_s2 <= 1'b1;
            dp_s1 <= 1'b1;
            dp_s2 <= 1'b1;
        end else begin
            rst_s1 <= link.bus_reset_n;
            rst_s2 <= rst_s1;
            halt_s1 <= link.clock_halt_req_n;
            halt_s2 <= halt_s1;
            slp_s1 <= link.sleep_req_n;
            slp_s2 <= slp_s1;
            dp_s1 <= link.deep_sleep_req_n;
            dp_s2 <= dp_s1;
        end
    end

    wire reset_rise = rst_s2 && !rst_d;
    wire halt_release = halt_s2 && !halt_d;

    // Straps sampled at the synchronised release, inside the hold window
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_d <= 1'b0;
            halt_d <= 1'b1;
            strap_addr <= '0;
            strap_br0 <= 1'b0;
            in_reset <= 1'b1;
            sleeping <= 1'b0;
        end else begin
            rst_d <= rst_s2;
            halt_d <= halt_s2;
            if (reset_rise) begin
                strap_addr <= link.addr_strap;
                strap_br0 <= !link.bus_request0_strap_n;
            end
            in_reset <= !rst_s2;
            sleeping <= !slp_s2;
        end
    end

    // Alert held at least the minimum time once raised by this end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hot_cnt <= '0;
            hot_n <= 1'b1;
            trip_n <= 1'b1;
        end else begin
            if (hot_event) begin
                hot_n <= 1'b0;
                hot_cnt <= '0;
            end else if (!hot_n) begin
                if (hot_cnt >= CNT_W'(HOT_MIN_CYC - 1)) hot_n <= 1'b1;
                else hot_cnt <= hot_cnt + CNT_W'(1);
            end
            // Trip latches until reset; power removal is the system's job
            if (trip_event) trip_n <= 1'b0;
        end
    end

    // Float error updates while running and on halt release (2 cycle
    // sync plus one register, inside the 5-cycle bound); set beats clear.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            float_error_n_lat <= 1'b0;
            float_error_n_n <= 1'b1;
            grant <= 1'b0;
            vid <= VID_RESET;
        end else begin
            if (fp_error) float_error_n_lat <= 1'b1;
            else if (in_reset) float_error_n_lat <= 1'b0;
            if (halt_s2 || halt_release)
                float_error_n_n <= !(float_error_n_lat || fp_error);
            grant <= !halt_s2 && rst_s2;
            vid <= !dp_s2 ? deep_voltage_code : run_voltage_code;
        end
    end

    // Test data on clk alone: the test clock toggles at every clk edge, so
    // it rises where it is seen low and falls where it is seen high.
    wire tck_rising = !link.tck;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tdi_q <= 1'b0;
            tdo_q <= 1'b0;
        end else if (!link.trst_n) begin
            tdi_q <= 1'b0;
            tdo_q <= 1'b0;
        end else if (tck_rising) begin
            tdi_q <= link.tdi;
        end else begin
            tdo_q <= tdi_q;
        end
    end

    assign link.stop_grant = grant;
    assign link.thermal_alert_n = hot_n;
    assign link.overheat_trip_n = trip_n;
    assign link.float_error_n = float_error_n_n;
    assign link.voltage_code_out = vid;
    assign link.tdo = tdo_q;
endmodule : cpu_power_ctrl

// ==== test/seq_properties.sv ====
/*
 * Checker for the sequencing link between the two ends.
 * Assumes it sits beside the interface on the shared clk.
 */
`timescale 1ns/10ps
module seq_properties
    import seq_pkg::*;
#(
    parameter int RESET_HOLD_CYC = PG_TO_RST_MIN_CYC
) (
    // Clock and reset
    input logic clk,
    input logic rstn,
    // System end levels
    input logic power_good_in,
    input logic bus_reset_n,
    input logic clock_halt_req_n,
    input logic sleep_req_n,
    input logic deep_sleep_req_n,
    input logic [31:3] addr_strap,
    input logic bus_request0_strap_n,
    input logic trst_n,
    input logic tms,
    input logic tck,
    input logic tdi,
    // Processor end levels
    input logic stop_grant,
    input logic tdo
);
    logic [CNT_W-1:0] pg_cnt;
    logic [CNT_W-1:0] grant_cnt;
    logic [CNT_W-1:0] lock_cnt;
    wire [29:0] straps = {addr_strap, bus_request0_strap_n};
    wire [32:0] hold_set = {power_good_in, bus_reset_n, deep_sleep_req_n,
        straps};
    // Grant and lock counters saturate so a long run cannot wrap them; pg_cnt only stops counting once bus reset is released
    wire [CNT_W-1:0] next_pg_cnt = !power_good_in ? '0 :
        (!bus_reset_n ? pg_cnt + 1 : pg_cnt);
    wire [CNT_W-1:0] next_grant_cnt = !stop_grant ? '0 :
        (grant_cnt < 1000 ? grant_cnt + 1 : grant_cnt);
    wire [CNT_W-1:0] next_lock_cnt = !deep_sleep_req_n ? '0 :
        (lock_cnt < LOCK_CYC ? lock_cnt + 1 : lock_cnt);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pg_cnt <= '0;
            grant_cnt <= '0;
            lock_cnt <= CNT_W'(LOCK_CYC);
        end else begin
            pg_cnt <= next_pg_cnt;
            grant_cnt <= next_grant_cnt;
            lock_cnt <= next_lock_cnt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_PG_HOLD: assert property (
        $rose(power_good_in) |-> power_good_in[*2])
        else $error("power good pulse too short");
    AST_PG_LOW: assert property (
        $fell(power_good_in) |->
        !power_good_in[*8] ##1 !power_good_in ##1 !power_good_in)
        else $error("power good low pulse too short");
    AST_RST_HOLD: assert property (
        $rose(bus_reset_n) |-> power_good_in && pg_cnt >= RESET_HOLD_CYC)
        else $error("bus reset released too early");
    AST_STRAP_SETUP: assert property (
        $rose(bus_reset_n) |-> straps == $past(straps, 4))
        else $error("straps moved before reset release");
    AST_STRAP_HOLD: assert property (
        $rose(bus_reset_n) |-> $stable(straps)[*3])
        else $error("straps moved after reset release");
    AST_SLP_GRANT: assert property (
        $fell(sleep_req_n) |-> grant_cnt >= SLP_AFTER_GRANT_CYC)
        else $error("sleep too soon after grant");
    AST_SLP_STABLE: assert property (
        $fell(sleep_req_n) |-> hold_set == $past(hold_set, 10))
        else $error("inputs moved before sleep");
    AST_DEEP_GAP: assert property (
        $fell(deep_sleep_req_n) |-> !sleep_req_n && !$past(sleep_req_n, 10))
        else $error("deep sleep too soon after sleep");
    AST_DEEP_IN: assert property (
        !deep_sleep_req_n |-> !sleep_req_n)
        else $error("deep sleep outside sleep");
    AST_LOCK: assert property (
        $rose(sleep_req_n) |-> lock_cnt == LOCK_CYC)
        else $error("sleep released before lock time");
    AST_HALT_HOLD: assert property (
        $rose(sleep_req_n) |-> (!clock_halt_req_n && $stable(hold_set))[*8]
        ##1 !clock_halt_req_n ##1 !clock_halt_req_n)
        else $error("halt or inputs moved after sleep release");
    AST_TRST: assert property (
        $fell(trst_n) |-> !trst_n[*4])
        else $error("test reset too short");
    AST_TMS_HIGH: assert property (
        $rose(trst_n) |-> tms)
        else $error("test mode select low at test reset release");
    AST_TDO_FALL: assert property (
        (tck && trst_n && $past(trst_n)) |=> tdo == $past(tdi, 2))
        else $error("test data out not the bit taken at rising clock");
    AST_SLEEP_CONST: assert property (
        (!sleep_req_n && !$past(sleep_req_n)) |->
        $stable({straps, power_good_in, clock_halt_req_n}))
        else $error("input moved during sleep");

    cover property ($rose(bus_reset_n));
    cover property ($fell(deep_sleep_req_n));
    cover property ($rose(sleep_req_n));
endmodule : seq_properties

// ==== test/tb_top.sv ====
/*
 * Bench joining both ends through the interface, driving user sides.
 * Assumes one 20 MHz clock and shortened reset and trip counts.
 */
`timescale 1ns/10ps
module tb_top;
    import seq_pkg::*;
    localparam int RESET_HOLD = 50;
    localparam int TRIP_OFF = 100;
    localparam logic [VID_W-1:0] DEEP_CODE = 5'h13;
    localparam logic [VID_W-1:0] RUN_CODE = 5'h0a;
    localparam logic [31:3] STRAP = 29'h0abc_1234;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic power_on = 1'b0;
    logic fp_error = 1'b0;
    // Sleep, deep, wake, test reset, hot, trip
    logic [5:0] cmd = 6'h00;
    logic [31:3] strap_cfg = '0;
    logic br0_cfg = 1'b0;
    logic running;
    logic vcore_enable;
    logic [31:3] strap_seen;
    logic deep_seen;
    logic [VID_W-1:0] vid_seen;
    logic br0_seen;
    logic in_reset;
    logic sleeping;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    seq_if seq_if_i ();
    sys_sequencer #(.RESET_HOLD_CYC(RESET_HOLD), .TRIP_OFF_CYC(TRIP_OFF))
    sys_sequencer_i (
        .clk(clk), .rstn(rstn), .power_on(power_on), .sleep_cmd(cmd[0]),
        .deep_cmd(cmd[1]), .wake_cmd(cmd[2]), .test_reset_cmd(cmd[3]),
        .strap_addr_cfg(strap_cfg), .strap_br0_cfg(br0_cfg),
        .running(running), .in_deep_sleep(deep_seen),
        .vcore_enable(vcore_enable),
        .voltage_code_seen(vid_seen), .link(seq_if_i.sys));
    cpu_power_ctrl cpu_power_ctrl_i (
        .clk(clk), .rstn(rstn), .hot_event(cmd[4]), .trip_event(cmd[5]),
        .fp_error(fp_error), .deep_voltage_code(DEEP_CODE),
        .run_voltage_code(RUN_CODE), .strap_addr(strap_seen),
        .strap_br0(br0_seen), .in_reset(in_reset), .sleeping(sleeping),
        .link(seq_if_i.cpu));
    seq_properties #(.RESET_HOLD_CYC(RESET_HOLD)) seq_properties_i (
        .clk(clk), .rstn(rstn), .power_good_in(seq_if_i.power_good_in),
        .bus_reset_n(seq_if_i.bus_reset_n),
        .clock_halt_req_n(seq_if_i.clock_halt_req_n),
        .sleep_req_n(seq_if_i.sleep_req_n),
        .deep_sleep_req_n(seq_if_i.deep_sleep_req_n),
        .addr_strap(seq_if_i.addr_strap),
        .bus_request0_strap_n(seq_if_i.bus_request0_strap_n),
        .trst_n(seq_if_i.trst_n), .tms(seq_if_i.tms), .tck(seq_if_i.tck),
        .tdi(seq_if_i.tdi), .stop_grant(seq_if_i.stop_grant),
        .tdo(seq_if_i.tdo));

    always #25 clk = ~clk;

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // Whole tests take about 11000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            $display("MISMATCH timeout expected 0 seen 1");
            results();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    function automatic logic cond(input int s);
        case (s)
            0: cond = running;
            1: cond = seq_if_i.bus_reset_n;
            2: cond = seq_if_i.stop_grant;
            3: cond = !seq_if_i.sleep_req_n;
            4: cond = !seq_if_i.deep_sleep_req_n;
            5: cond = seq_if_i.voltage_code_out === DEEP_CODE;
            6: cond = seq_if_i.deep_sleep_req_n;
            7: cond = seq_if_i.sleep_req_n;
            8: cond = seq_if_i.clock_halt_req_n;
            9: cond = !seq_if_i.float_error_n;
            10: cond = !seq_if_i.thermal_alert_n;
            11: cond = seq_if_i.thermal_alert_n;
            12: cond = !seq_if_i.trst_n;
            13: cond = seq_if_i.trst_n;
            14: cond = !seq_if_i.overheat_trip_n;
            15: cond = !vcore_enable;
            16: cond = !seq_if_i.power_good_in;
            17: cond = seq_if_i.power_good_in;
            default: cond = 1'b0;
        endcase
    endfunction : cond

    // Counts edges until the condition is seen, bounded by lim
    task automatic wait_for(input int s, input int lim, output int cnt);
        cnt = 0;
        while (cond(s) !== 1'b1 && cnt < lim) begin
            @(posedge clk);
            cnt++;
        end
        if (cond(s) !== 1'b1) begin
            fail_count++;
            $display("MISMATCH wait_%0d expected 1 seen 0", s);
        end
    endtask : wait_for

    task automatic pulse(input int i);
        @(posedge clk);
        cmd[i] <= 1'b1;
        @(posedge clk);
        cmd[i] <= 1'b0;
    endtask : pulse

    initial begin
        repeat (19) @(posedge clk);
        check("pg_reset", seq_if_i.power_good_in, 1'b0);
        check("bus_reset", seq_if_i.bus_reset_n, 1'b0);
        check("in_reset", in_reset, 1'b1);
        @(posedge clk);
        rstn <= 1'b1;
        strap_cfg <= STRAP;
        br0_cfg <= 1'b1;
        power_on <= 1'b1;
        wait_for(17, 100, n);
        wait_for(1, 200, n);
        check("reset_hold", n >= RESET_HOLD, 1'b1);
        wait_for(0, 50, n);
        check("strap_addr", strap_seen, STRAP);
        check("strap_br0", br0_seen, 1'b1);
        check("out_of_reset", in_reset, 1'b0);
        check("vcore", vcore_enable, 1'b1);
        pulse(1);
        repeat (20) @(posedge clk);
        check("deep_refused", seq_if_i.deep_sleep_req_n, 1'b1);
        pulse(0);
        wait_for(2, 20, n);
        fp_error <= 1'b1;
        wait_for(3, 300, n);
        check("sleep_gap", n >= SLP_AFTER_GRANT_CYC, 1'b1);
        repeat (12) @(posedge clk);
        pulse(1);
        wait_for(4, 20, n);
        wait_for(5, VID_MAX_CYC + 1, n);
        check("vid_delay", n <= VID_MAX_CYC, 1'b1);
        check("deep_state", deep_seen, 1'b1);
        check("sleeping", sleeping, 1'b1);
        pulse(2);
        wait_for(6, 20, n);
        check("vid_seen", vid_seen, DEEP_CODE);
        wait_for(7, 1000, n);
        check("lock", n >= LOCK_CYC, 1'b1);
        wait_for(8, 50, n);
        check("halt_hold", n >= HALT_HOLD_CYC, 1'b1);
        check("awake", sleeping, 1'b0);
        wait_for(9, 10, n);
        check("float_error_n_delay", n <= FLOAT_ERROR_N_MAX_CYC, 1'b1);
        fp_error <= 1'b0;
        pulse(4);
        wait_for(10, 20, n);
        wait_for(11, 12000, n);
        check("hot_width", n >= HOT_MIN_CYC, 1'b1);
        pulse(3);
        wait_for(12, 20, n);
        wait_for(13, 50, n);
        check("trst_width", n >= 2 * TRST_MIN_TCK, 1'b1);
        @(posedge clk);
        power_on <= 1'b0;
        wait_for(16, 20, n);
        power_on <= 1'b1;
        wait_for(17, 100, n);
        check("pg_low", n >= PG_LOW_MIN_CYC, 1'b1);
        wait_for(0, 300, n);
        pulse(5);
        wait_for(14, 20, n);
        wait_for(15, TRIP_OFF + 5, n);
        check("trip_off", n <= TRIP_OFF, 1'b1);
        results();
    end
endmodule : tb_top
